// *** rtl/pilc_consts.svh ***
/*
  Constants of the prioritized interrupt latch controller: register
  addresses, field positions, reset values and vector figures.
  Assumes it is included by bare name from files under rtl/.
*/
`ifndef PILC_CONSTS_SVH
`define PILC_CONSTS_SVH

// Register addresses on the special-function register port
`define PILC_ADDR_ENABLE_LO 8'h3A
`define PILC_ADDR_ENABLE_HI 8'h3B
`define PILC_ADDR_PENDING_LO 8'h3C
`define PILC_ADDR_PENDING_HI 8'h3D
`define PILC_ADDR_SELECTOR 8'h3E

// Field positions
`define PILC_BIT_MASTER 0
`define PILC_BIT_SEL_LEVEL10 6
`define PILC_BIT_SEL_LEVEL15 1
`define PILC_BIT_SEL_LEVEL16 0

// Latch bit numbers of special sources
`define PILC_IDX_SOFT 4'h0
`define PILC_IDX_TRAP 4'h2
`define PILC_IDX_WDOG 4'h3
`define PILC_IDX_EXT0 4'h4
`define PILC_IDX_LEVEL10 4'h9
`define PILC_IDX_LEVEL15 4'hE
`define PILC_IDX_LEVEL16 4'hF

// Reset values
`define PILC_RST_BYTE 8'h00
`define PILC_RST_LATCH 14'h0000
`define PILC_RST_ENABLE 12'h000
`define PILC_RST_IDX 4'h0

// Vectors: reset, shared soft/undefined, and the base the others count down
`define PILC_VEC_RESET 16'hFFFE
`define PILC_VEC_SOFT 16'hFFFC
`define PILC_VEC_BASE 16'hFFFE

`endif

// *** rtl/pilc_pkg.sv ***
/*
  Types of the prioritized interrupt latch controller.
  Assumes nothing of its surroundings.
*/
package pilc_pkg;

  // Index of a request slot, 0 for the unlatched soft sources, 2..15 latched
  typedef logic [3:0] pilc_idx_t;

  // CPU vector address
  typedef logic [15:0] pilc_vec_t;

  // Request slots, one bit per latch number
  typedef logic [15:0] pilc_slots_t;

endpackage : pilc_pkg

// *** rtl/pilc_prio_pick.sv ***
/*
  Fixed-priority picker: the lowest set slot number wins.
  Assumes a one-hot or many-hot request vector from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pilc_consts.svh"

module pilc_prio_pick (
  // Requests, one per slot
  input wire pilc_pkg::pilc_slots_t req,
  // Result
  output logic found,
  output pilc_pkg::pilc_idx_t idx
);

  // Scan from the lowest priority upward so the lowest number is kept
  always_comb begin
    found = 1'b0;
    idx = `PILC_RST_IDX;
    for (int i = 15; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 4'(i);
      end
    end
  end

endmodule : pilc_prio_pick

`default_nettype wire

// *** rtl/pilc_ctrl.sv ***
/*
  Prioritized interrupt latch controller: pending latches, master and
  per-source enables, shared-level selector, priority pick and vector
  hand-off to the CPU core, with the enable, pending and selector
  registers on the special-function register port.
  Assumes every latched request input is a one-cycle pulse made by logic on
  clk_sys (pins already synchronised and edge-detected upstream), that
  the CPU core stacks the master flag itself and drives it back on return.
  Limitations: software may still clear latch bits 2 and 3, and a clear
  done by read-modify-write can lose a request arriving between the read
  and the write; both are left to the software's discipline.
  The soft and bad-opcode inputs are levels and must stand until taken.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pilc_consts.svh"

module pilc_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Non-maskable sources
  input wire logic software_irq,
  input wire logic bad_opcode_irq,
  input wire logic address_trap_irq,
  input wire logic watchdog_irq,
  // Action selects from the watchdog control register
  input wire logic trap_action_select,
  input wire logic watchdog_action_select,
  // Maskable sources
  input wire logic external_irq_zero,
  input wire logic ext0_pin_enable,
  input wire logic external_irq_one,
  input wire logic time_base_irq,
  input wire logic external_irq_two,
  input wire logic timer_counter_irq,
  input wire logic serial_receive_irq,
  input wire logic serial_io_irq,
  input wire logic serial_transmit_irq,
  input wire logic timer4_irq,
  input wire logic timer6_irq,
  input wire logic converter_done_irq,
  input wire logic external_irq_three,
  input wire logic timer3_irq,
  input wire logic external_irq_five,
  input wire logic timer5_irq,
  // CPU core hand-off
  output logic cpu_irq_req,
  output logic [15:0] cpu_vector,
  output logic [3:0] cpu_source_idx,
  input wire logic cpu_accept,
  input wire logic cpu_return,
  input wire logic cpu_return_master,
  output logic master_enable_flag,
  // Malfunction reset requests
  output logic trap_reset_req,
  output logic watchdog_reset_req
);

  // Vector of a slot: the soft pair shares one, the rest count down by two
  // from the top, two bytes per slot number
  function automatic pilc_pkg::pilc_vec_t vec_of(input pilc_pkg::pilc_idx_t i);
    if (i == `PILC_IDX_SOFT)
      return `PILC_VEC_SOFT;
    return 16'(`PILC_VEC_BASE - {11'h000, i, 1'b0});
  endfunction : vec_of

  // Register state; every flop has a synchronous reset
  logic [15:2] pending_latch_ff;
  logic [15:2] nxt_pending_latch;
  logic [15:4] source_enable_flag_ff;
  logic [15:4] nxt_source_enable_flag;
  logic master_enable_flag_ff;
  logic nxt_master_enable_flag;
  logic level10_select_ff;
  logic level15_select_ff;
  logic level16_select_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Offered request, held in flops so vector and index agree at acceptance
  logic req_ff;
  pilc_pkg::pilc_idx_t idx_ff;
  pilc_pkg::pilc_vec_t vec_ff;
  logic trap_rst_ff;
  logic wdog_rst_ff;

  // Address decode; only exact matches respond, every other address
  // reads zero and ignores writes
  wire hit_en_lo = sfr_addr == `PILC_ADDR_ENABLE_LO;
  wire hit_en_hi = sfr_addr == `PILC_ADDR_ENABLE_HI;
  wire hit_pend_lo = sfr_addr == `PILC_ADDR_PENDING_LO;
  wire hit_pend_hi = sfr_addr == `PILC_ADDR_PENDING_HI;
  wire hit_sel = sfr_addr == `PILC_ADDR_SELECTOR;
  wire wr_en_lo = sfr_wr & hit_en_lo;
  wire wr_en_hi = sfr_wr & hit_en_hi;
  wire wr_pend_lo = sfr_wr & hit_pend_lo;
  wire wr_pend_hi = sfr_wr & hit_pend_hi;
  wire wr_sel = sfr_wr & hit_sel;

  // Trap and watchdog either ask for reset or latch, never both
  // The selects are levels held in the watchdog control register
  wire trap_to_latch = address_trap_irq & ~trap_action_select;
  wire wdog_to_latch = watchdog_irq & ~watchdog_action_select;

  // Shared levels: only the chosen source reaches the latch
  // A request from the other source is dropped, never held for later
  wire level10_src = level10_select_ff ? serial_io_irq
                                       : serial_receive_irq;
  wire level15_src = level15_select_ff ? timer3_irq
                                       : external_irq_three;
  wire level16_src = level16_select_ff ? timer5_irq
                                       : external_irq_five;

  // Hardware set terms, one per latch bit; soft pair has none
  wire [15:2] hw_set = {level16_src,
                        level15_src,
                        converter_done_irq,
                        timer6_irq,
                        timer4_irq,
                        serial_transmit_irq,
                        level10_src,
                        timer_counter_irq,
                        external_irq_two,
                        time_base_irq,
                        external_irq_one,
                        external_irq_zero,
                        wdog_to_latch,
                        trap_to_latch};

  // Software clear: a written 0 clears, a written 1 leaves the bit alone
  // Bits 1..0 of the low byte hold no latch and are ignored
  wire [15:2] sw_clear = {wr_pend_hi ? ~sfr_wdata : 8'h00,
                          wr_pend_lo ? ~sfr_wdata[7:2] : 6'h00};

  // The CPU takes the offer only while one stands; a stray accept pulse
  // with nothing offered must neither clear a latch nor drop the master
  wire accept_taken = cpu_accept & req_ff;

  // Acceptance clear of the offered latched slot; the soft pair has none
  wire acc_latched = accept_taken & (idx_ff != `PILC_IDX_SOFT);
  wire [15:0] acc_onehot = acc_latched ? (16'h0001 << idx_ff) : 16'h0000;
  wire [15:2] acc_clear = acc_onehot[15:2];

  // Both kinds of clear merged; a request in the same cycle outranks them
  // so that an event landing on a clear write is never lost
  wire [15:2] any_clear = sw_clear | acc_clear;
  wire [15:2] kept_latch = pending_latch_ff & ~any_clear;
  assign nxt_pending_latch = kept_latch | hw_set;

  // Enable gating; external zero also needs its pin enabled
  // Enables gate only the offer; a latch records its event regardless
  wire [15:4] gate_en = source_enable_flag_ff
                        & {11'h7FF, ext0_pin_enable};
  wire [15:4] maskable_ok = pending_latch_ff[15:4] & gate_en
                            & {12{master_enable_flag_ff}};
  wire soft_req = software_irq | bad_opcode_irq;

  // Candidate slots: non-maskables ignore every enable
  // Slot 1 stays empty: bad opcode shares slot 0 with the soft source
  wire [15:0] candidates = {maskable_ok,
                            pending_latch_ff[3:2],
                            1'b0,
                            soft_req};

  // Fixed-order pick; the soft pair is placed ahead of trap and watchdog
  // Trap and watchdog carry no order of their own; this one is a choice
  logic pick_found;
  pilc_pkg::pilc_idx_t pick_idx;

  pilc_prio_pick pilc_prio_pick_i (
    .req(candidates),
    .found(pick_found),
    .idx(pick_idx)
  );

  // While the CPU takes the offered slot, withdraw it for one cycle so a
  // stale offer is never seen twice
  wire nxt_req = pick_found & ~cpu_accept;

  // Master enable: acceptance beats return, return beats a register write.
  // The CPU stacks the old value itself; this block only clears and reloads.
  always_comb begin
    nxt_master_enable_flag = master_enable_flag_ff;
    if (accept_taken)
      nxt_master_enable_flag = 1'b0;
    else if (cpu_return)
      nxt_master_enable_flag = cpu_return_master;
    else if (wr_en_lo)
      nxt_master_enable_flag = sfr_wdata[`PILC_BIT_MASTER];
  end

  // Individual enable flags, bits 4..15 across the two enable bytes
  // Bits 3..1 of the low byte hold nothing and are dropped
  assign nxt_source_enable_flag = {
    wr_en_hi ? sfr_wdata : source_enable_flag_ff[15:8],
    wr_en_lo ? sfr_wdata[7:4] : source_enable_flag_ff[7:4]};

  // Read mux; missing low bits and unmapped addresses read as zero
  wire [7:0] rd_en_lo = {source_enable_flag_ff[7:4], 3'h0,
                         master_enable_flag_ff};
  wire [7:0] rd_sel = {1'b0, level10_select_ff, 4'h0,
                       level15_select_ff, level16_select_ff};
  wire [7:0] rd_en_hi = source_enable_flag_ff[15:8];
  wire [7:0] rd_pend_lo = {pending_latch_ff[7:2], 2'h0};
  wire [7:0] rd_pend_hi = pending_latch_ff[15:8];
  assign nxt_rdata = hit_en_lo ? rd_en_lo
                   : hit_en_hi ? rd_en_hi
                   : hit_pend_lo ? rd_pend_lo
                   : hit_pend_hi ? rd_pend_hi
                   : hit_sel ? rd_sel
                   : `PILC_RST_BYTE;

  // Pending latches
  always_ff @(posedge clk_sys) begin
    if (srst)
      pending_latch_ff <= `PILC_RST_LATCH;
    else
      pending_latch_ff <= nxt_pending_latch;
  end

  // Individual enable flags; reset leaves every maskable source shut
  always_ff @(posedge clk_sys) begin
    if (srst)
      source_enable_flag_ff <= `PILC_RST_ENABLE;
    else
      source_enable_flag_ff <= nxt_source_enable_flag;
  end

  // Master enable flag; reset leaves it clear
  always_ff @(posedge clk_sys) begin
    if (srst)
      master_enable_flag_ff <= 1'b0;
    else
      master_enable_flag_ff <= nxt_master_enable_flag;
  end

  // Shared-level selector
  // Set it before the shared sources ask; held requests are not moved
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level10_select_ff <= 1'b0;
      level15_select_ff <= 1'b0;
      level16_select_ff <= 1'b0;
    end else if (wr_sel) begin
      level10_select_ff <= sfr_wdata[`PILC_BIT_SEL_LEVEL10];
      level15_select_ff <= sfr_wdata[`PILC_BIT_SEL_LEVEL15];
      level16_select_ff <= sfr_wdata[`PILC_BIT_SEL_LEVEL16];
    end
  end

  // Read data, captured on a read strobe and held until the next one
  // so a slow fetch on the CPU side still sees a settled byte
  always_ff @(posedge clk_sys) begin
    if (srst)
      rdata_ff <= `PILC_RST_BYTE;
    else if (sfr_rd)
      rdata_ff <= nxt_rdata;
  end

  // Offer flag to the CPU
  always_ff @(posedge clk_sys) begin
    if (srst)
      req_ff <= 1'b0;
    else
      req_ff <= nxt_req;
  end

  // Index and vector move only with a winner, so while idle they keep the
  // last one, and the reset vector until the first request arrives
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idx_ff <= `PILC_RST_IDX;
      vec_ff <= `PILC_VEC_RESET;
    end else if (pick_found) begin
      idx_ff <= pick_idx;
      vec_ff <= vec_of(pick_idx);
    end
  end

  // Trap reset request, a one-cycle pulse; the trap never latches then
  always_ff @(posedge clk_sys) begin
    if (srst)
      trap_rst_ff <= 1'b0;
    else
      trap_rst_ff <= address_trap_irq & trap_action_select;
  end

  // Watchdog reset request, a one-cycle pulse
  always_ff @(posedge clk_sys) begin
    if (srst)
      wdog_rst_ff <= 1'b0;
    else
      wdog_rst_ff <= watchdog_irq & watchdog_action_select;
  end

  // Outputs
  assign sfr_rdata = rdata_ff;
  assign cpu_irq_req = req_ff;
  assign cpu_vector = vec_ff;
  assign cpu_source_idx = idx_ff;
  assign master_enable_flag = master_enable_flag_ff;
  assign trap_reset_req = trap_rst_ff;
  assign watchdog_reset_req = wdog_rst_ff;

endmodule : pilc_ctrl

`default_nettype wire

// *** bench/pilc_cpu_model.sv ***
/*
  CPU core model: takes a standing interrupt offer after a set wait.
  Assumes the controller holds its offer until the accept edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pilc_cpu_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bench controls: accept on or off, cycles to wait first
  input wire logic enable,
  input wire logic [1:0] delay,
  // Controller hand-off
  input wire logic cpu_irq_req,
  output logic cpu_accept
);
  logic [1:0] wait_ff;

  // Accept is one cycle long, so the same offer is never taken twice
  always_ff @(posedge clk_sys) begin
    if (srst || !cpu_irq_req || cpu_accept || !enable) begin
      wait_ff <= 2'h0;
      cpu_accept <= 1'b0;
    end else if (wait_ff == delay) begin
      cpu_accept <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule : pilc_cpu_model

`default_nettype wire

// *** bench/pilc_ctrl_sva.sv ***
/*
  Checker of the interrupt latch controller ports.
  Assumes it is bound to pilc_ctrl on the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pilc_ctrl_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Sources and action selects
  input wire logic software_irq,
  input wire logic address_trap_irq,
  input wire logic watchdog_irq,
  input wire logic trap_action_select,
  input wire logic watchdog_action_select,
  // CPU hand-off
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vector,
  input wire logic [3:0] cpu_source_idx,
  input wire logic cpu_accept,
  input wire logic cpu_return,
  input wire logic cpu_return_master,
  input wire logic master_enable_flag,
  input wire logic trap_reset_req,
  input wire logic watchdog_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Unmapped reads give zero; read data holds between reads
  unmapped_read_a: assert property (sfr_rd && sfr_addr == 8'h40
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  // Acceptance drops the offer and the master flag
  accept_clear_a: assert property (cpu_accept && cpu_irq_req
    |=> !cpu_irq_req && !master_enable_flag) else $error("accept ignored");
  vector_map_a: assert property (cpu_irq_req |-> cpu_vector ==
    (cpu_source_idx == 4'h0 ? 16'hFFFC
    : 16'hFFFE - {11'h000, cpu_source_idx, 1'b0})) else $error("bad vector");
  // A fresh maskable offer needs the master flag set before it
  mask_gate_a: assert property (cpu_irq_req && !$past(cpu_irq_req)
    && cpu_source_idx > 4'h3 |-> $past(master_enable_flag))
    else $error("maskable offer while master off");
  return_reload_a: assert property (cpu_return && !cpu_accept
    |=> master_enable_flag == $past(cpu_return_master))
    else $error("return did not reload master");
  trap_reset_a: assert property (address_trap_irq && trap_action_select
    |=> trap_reset_req) else $error("trap reset missing");
  wdog_reset_a: assert property (watchdog_irq && watchdog_action_select
    |=> watchdog_reset_req) else $error("watchdog reset missing");
  soft_offer_a: assert property ($rose(software_irq)
    |-> ##[1:3] cpu_irq_req) else $error("soft request not offered");
endmodule : pilc_ctrl_sva

bind pilc_ctrl pilc_ctrl_sva pilc_ctrl_sva_i (
  .clk_sys, .srst, .sfr_addr, .sfr_rd, .sfr_rdata, .software_irq,
  .address_trap_irq, .watchdog_irq, .trap_action_select,
  .watchdog_action_select, .cpu_irq_req, .cpu_vector, .cpu_source_idx,
  .cpu_accept, .cpu_return, .cpu_return_master, .master_enable_flag,
  .trap_reset_req, .watchdog_reset_req
);

`default_nettype wire

// *** bench/pilc_ctrl_tb.sv ***
/*
  Self-checking bench of the interrupt latch controller.
  Assumes the CPU model and the checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none

module pilc_ctrl_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [18:0] s = 19'h00000;
  logic tsel = 1'b1;
  logic wsel = 1'b1;
  logic pin_en = 1'b0;
  logic ret = 1'b0;
  logic ret_m = 1'b0;
  logic cpu_en = 1'b0;
  logic [1:0] delay = 2'h0;
  logic [7:0] sfr_rdata;
  logic [15:0] cpu_vector;
  logic cpu_irq_req, cpu_accept, master, trap_rst, wdog_rst;
  int n_errors = 0;
  int checks_done = 0;
  int i;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  // Slots 4..15 on s[4..15]; shared alternates on s[16..18]
  pilc_ctrl pilc_ctrl_i (.clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .software_irq(s[0]), .bad_opcode_irq(s[1]),
    .address_trap_irq(s[2]), .watchdog_irq(s[3]),
    .trap_action_select(tsel), .watchdog_action_select(wsel),
    .external_irq_zero(s[4]), .ext0_pin_enable(pin_en),
    .external_irq_one(s[5]), .time_base_irq(s[6]), .external_irq_two(s[7]),
    .timer_counter_irq(s[8]), .serial_receive_irq(s[9]),
    .serial_io_irq(s[16]), .serial_transmit_irq(s[10]), .timer4_irq(s[11]),
    .timer6_irq(s[12]), .converter_done_irq(s[13]),
    .external_irq_three(s[14]), .timer3_irq(s[17]),
    .external_irq_five(s[15]), .timer5_irq(s[18]),
    .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector), .cpu_source_idx(),
    .cpu_accept(cpu_accept), .cpu_return(ret), .cpu_return_master(ret_m),
    .master_enable_flag(master), .trap_reset_req(trap_rst),
    .watchdog_reset_req(wdog_rst));

  pilc_cpu_model pilc_cpu_model_i (.clk_sys(clk_sys), .srst(srst),
    .enable(cpu_en), .delay(delay), .cpu_irq_req(cpu_irq_req),
    .cpu_accept(cpu_accept));

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobe dropped with an edge between, so no signal moves twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    sfr_wr = 1'b0;
    tick;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick;
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, e});
    tick;
  endtask : rd

  task automatic pulse(input int n);
    s[n] = 1'b1;
    tick;
    s[n] = 1'b0;
    tick;
  endtask : pulse

  // Soft sources are held until the accept edge, then dropped
  task automatic take(input logic [15:0] e);
    int k;
    for (k = 0; k < 20 && cpu_accept !== 1'b1; k++) tick;
    chk({15'h0000, cpu_accept}, 16'h0001);
    chk(cpu_vector, e);
    s[1:0] = 2'b00;
    tick;
  endtask : take

  task automatic back(input logic m);
    ret = 1'b1;
    ret_m = m;
    tick;
    ret = 1'b0;
    chk({15'h0000, master}, {15'h0000, m});
    tick;
  endtask : back

  task automatic test_done;
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (16) tick;
    srst = 1'b0;
    rd(8'h3A, 8'h00);
    rd(8'h3C, 8'h00);
    rd(8'h40, 8'h00);
    chk(cpu_vector, 16'hFFFE);
    for (i = 4; i < 19; i++) pulse(i);
    rd(8'h3C, 8'hF0);
    wr(8'h3D, 8'h00);
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h00);
    wr(8'h3E, 8'h43);
    wr(8'h40, 8'hFF);
    rd(8'h3E, 8'h43);
    pulse(9);
    for (i = 14; i < 19; i++) pulse(i);
    rd(8'h3D, 8'hC2);
    wr(8'h3C, 8'h0C);
    rd(8'h3C, 8'h00);
    wr(8'h3B, 8'hFF);
    rd(8'h3B, 8'hFF);
    wr(8'h3A, 8'hF0);
    cpu_en = 1'b1;
    wr(8'h3A, 8'hF1);
    take(16'hFFEC);
    chk({15'h0000, master}, 16'h0000);
    delay = 2'h3;
    back(1'b1);
    take(16'hFFE2);
    back(1'b1);
    take(16'hFFE0);
    rd(8'h3D, 8'h00);
    back(1'b0);
    pulse(4);
    pulse(13);
    wr(8'h3A, 8'hF1);
    take(16'hFFE4);
    rd(8'h3C, 8'h10);
    pin_en = 1'b1;
    back(1'b1);
    take(16'hFFF6);
    s[2] = 1'b1;
    tick;
    s[2] = 1'b0;
    chk({15'h0000, trap_rst}, 16'h0001);
    tick;
    s[3] = 1'b1;
    tick;
    s[3] = 1'b0;
    chk({15'h0000, wdog_rst}, 16'h0001);
    tick;
    rd(8'h3C, 8'h00);
    tsel = 1'b0;
    wsel = 1'b0;
    cpu_en = 1'b0;
    s[3:2] = 2'b11;
    tick;
    s[3:2] = 2'b00;
    tick;
    rd(8'h3C, 8'h0C);
    cpu_en = 1'b1;
    take(16'hFFFA);
    take(16'hFFF8);
    for (i = 0; i < 2; i++) begin
      s[i] = 1'b1;
      take(16'hFFFC);
    end
    test_done;
  end

  // Hang guard, far beyond the roughly 170 cycles the tests need
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    test_done;
  end
endmodule : pilc_ctrl_tb

`default_nettype wire
